// >>> hdl/iad_decoder.sv
// Indirect address decoder: pointer pairs, region decode and access sequencing.
// Contract
// - Virtual access register has no storage; redirects.
// - Pointer at virtual register: read zero, drop write.
// - Pointer is high byte joined with low byte.
// - 0x000-0xFFF map to absolute data addresses.
// - 0x2000-0x29AF is linear banked RAM view.
// - Linear increments continue into next bank's RAM.
// - Common memory is excluded from linear region.
// - Unimplemented locations read as 0x00.
// - High pointer bit set selects flash word.
// - Flash reads return low eight bits only.
// - Writes to flash region never modify flash.
// - Flash access takes one extra cycle.
`timescale 1ns/1ps
`default_nettype none
module iad_decoder (
  input wire logic clk,
  input wire logic rst,
  input wire iad_pkg::iad_pwr_t ptr_wr,
  input wire iad_pkg::iad_acc_t acc,
  input wire logic [7:0] dm_rdata,
  input wire logic dm_impl,
  input wire logic [13:0] pf_rdata,
  output iad_pkg::iad_ptr_t ptr0,
  output iad_pkg::iad_ptr_t ptr1,
  output logic busy,
  output iad_pkg::iad_rsp_t rsp,
  output logic dm_en,
  output logic dm_we,
  output logic [11:0] dm_addr,
  output logic [7:0] dm_wdata,
  output logic pf_en,
  output logic [14:0] pf_addr
);

  iad_pkg::iad_ptr_t ptr_ff [2];
  iad_pkg::iad_state_t state_ff;
  iad_pkg::iad_state_t nxt_state;
  iad_pkg::iad_rsp_t rsp_ff;
  logic busy_ff;
  logic we_ff;
  logic dm_en_ff;
  logic dm_we_ff;
  logic [11:0] dm_addr_ff;
  logic [7:0] dm_wdata_ff;
  logic pf_en_ff;
  logic [14:0] pf_addr_ff;
  logic [15:0] cur_ptr;
  logic take;
  iad_pkg::iad_map_t cur_map;

  // Maps a full pointer onto a region and a data memory address.
  function automatic iad_pkg::iad_map_t map_ptr(input logic [15:0] p);
    iad_pkg::iad_map_t m;
    logic [11:0] n;
    logic [11:0] bank;
    logic [11:0] ofs;
    m.rg = iad_pkg::IAD_RG_NONE;
    m.addr = iad_pkg::IAD_DM_ADDR_RST;
    n = 12'(p - iad_pkg::IAD_LIN_BASE);
    bank = n / iad_pkg::IAD_RAM_BYTES;
    ofs = n % iad_pkg::IAD_RAM_BYTES;
    if (p[iad_pkg::IAD_PF_BIT]) begin
      m.rg = iad_pkg::IAD_RG_FLASH;
    end else if (p <= iad_pkg::IAD_TRAD_LAST) begin
      // The two virtual slots repeat in every bank, so only the low bits
      // are compared.
      if (p[6:0] == iad_pkg::IAD_VAR_SLOT0 ||
          p[6:0] == iad_pkg::IAD_VAR_SLOT1) begin
        m.rg = iad_pkg::IAD_RG_NONE;
      end else begin
        m.rg = iad_pkg::IAD_RG_DATA;
        m.addr = p[11:0];
      end
    end else if (p >= iad_pkg::IAD_LIN_BASE &&
                 p <= iad_pkg::IAD_LIN_LAST) begin
      // Banks hold 128 bytes; only the 80 banked RAM bytes from offset
      // 0x20 appear, so the common bytes never show here.
      m.rg = iad_pkg::IAD_RG_DATA;
      m.addr = {bank[4:0], 7'(iad_pkg::IAD_RAM_OFS + ofs[6:0])};
    end else begin
      m.rg = iad_pkg::IAD_RG_NONE;
    end
    return m;
  endfunction : map_ptr

  assign cur_ptr = {ptr_ff[acc.sel].hi, ptr_ff[acc.sel].lo};
  assign cur_map = map_ptr(cur_ptr);
  assign take = acc.valid && (state_ff == iad_pkg::IAD_ST_IDLE);

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      iad_pkg::IAD_ST_IDLE: begin
        if (take) begin
          case (cur_map.rg)
            iad_pkg::IAD_RG_DATA: nxt_state = iad_pkg::IAD_ST_DMEM;
            iad_pkg::IAD_RG_FLASH: nxt_state = iad_pkg::IAD_ST_FL1;
            default: nxt_state = iad_pkg::IAD_ST_NULL;
          endcase
        end
      end
      iad_pkg::IAD_ST_FL1: nxt_state = iad_pkg::IAD_ST_FL2;
      iad_pkg::IAD_ST_DMEM, iad_pkg::IAD_ST_NULL, iad_pkg::IAD_ST_FL2: begin
        nxt_state = iad_pkg::IAD_ST_IDLE;
      end
      default: nxt_state = iad_pkg::IAD_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff <= iad_pkg::IAD_ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Pointer bytes; a byte write beats a post-increment in the same cycle.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ptr_ff[0] <= iad_pkg::IAD_PTR_RST;
      ptr_ff[1] <= iad_pkg::IAD_PTR_RST;
    end else begin
      if (take && acc.inc) begin
        // Plain binary carry walks linear addresses across bank seams.
        ptr_ff[acc.sel] <= cur_ptr + 16'h0001;
      end
      if (ptr_wr.en) begin
        if (ptr_wr.hi) begin
          ptr_ff[ptr_wr.sel].hi <= ptr_wr.data;
        end else begin
          ptr_ff[ptr_wr.sel].lo <= ptr_wr.data;
        end
      end
    end
  end

  // Data memory port; nothing is stored locally behind the access port.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dm_en_ff <= 1'b0;
      dm_we_ff <= 1'b0;
      dm_addr_ff <= iad_pkg::IAD_DM_ADDR_RST;
      dm_wdata_ff <= iad_pkg::IAD_ZERO_BYTE;
    end else if (take && cur_map.rg == iad_pkg::IAD_RG_DATA) begin
      dm_en_ff <= 1'b1;
      dm_we_ff <= acc.we;
      dm_addr_ff <= cur_map.addr;
      dm_wdata_ff <= acc.wdata;
    end else begin
      dm_en_ff <= 1'b0;
      dm_we_ff <= 1'b0;
    end
  end

  // Flash port is read-only, held two cycles to cover the extra cycle.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pf_en_ff <= 1'b0;
      pf_addr_ff <= iad_pkg::IAD_PF_ADDR_RST;
    end else if (take && cur_map.rg == iad_pkg::IAD_RG_FLASH) begin
      pf_en_ff <= 1'b1;
      pf_addr_ff <= cur_ptr[14:0];
    end else if (state_ff == iad_pkg::IAD_ST_FL2) begin
      pf_en_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      we_ff <= 1'b0;
    end else if (take) begin
      we_ff <= acc.we;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy_ff <= 1'b0;
    end else begin
      busy_ff <= (nxt_state != iad_pkg::IAD_ST_IDLE);
    end
  end

  // Answer path; writes always answer zero.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rsp_ff.valid <= 1'b0;
      rsp_ff.rdata <= iad_pkg::IAD_ZERO_BYTE;
    end else begin
      rsp_ff.valid <= 1'b0;
      case (state_ff)
        iad_pkg::IAD_ST_DMEM: begin
          rsp_ff.valid <= 1'b1;
          rsp_ff.rdata <= (!we_ff && dm_impl) ? dm_rdata
                                              : iad_pkg::IAD_ZERO_BYTE;
        end
        iad_pkg::IAD_ST_NULL: begin
          rsp_ff.valid <= 1'b1;
          rsp_ff.rdata <= iad_pkg::IAD_ZERO_BYTE;
        end
        iad_pkg::IAD_ST_FL2: begin
          rsp_ff.valid <= 1'b1;
          rsp_ff.rdata <= we_ff ? iad_pkg::IAD_ZERO_BYTE
                                : pf_rdata[7:0];
        end
        default: rsp_ff.rdata <= rsp_ff.rdata;
      endcase
    end
  end

  assign ptr0 = ptr_ff[0];
  assign ptr1 = ptr_ff[1];
  assign busy = busy_ff;
  assign rsp = rsp_ff;
  assign dm_en = dm_en_ff;
  assign dm_we = dm_we_ff;
  assign dm_addr = dm_addr_ff;
  assign dm_wdata = dm_wdata_ff;
  assign pf_en = pf_en_ff;
  assign pf_addr = pf_addr_ff;

endmodule : iad_decoder
`default_nettype wire

// >>> hdl/iad_pkg.sv
// Shared constants and types for the indirect address decoder.
`default_nettype none
package iad_pkg;
  localparam logic [15:0] IAD_TRAD_LAST = 16'h0fff;
  localparam logic [15:0] IAD_LIN_BASE = 16'h2000;
  localparam logic [15:0] IAD_LIN_LAST = 16'h29af;
  localparam int IAD_PF_BIT = 15;
  localparam logic [11:0] IAD_RAM_BYTES = 12'h050;
  localparam logic [6:0] IAD_RAM_OFS = 7'h20;
  localparam logic [6:0] IAD_VAR_SLOT0 = 7'h00;
  localparam logic [6:0] IAD_VAR_SLOT1 = 7'h01;
  localparam logic [7:0] IAD_ZERO_BYTE = 8'h00;
  localparam logic [15:0] IAD_PTR_RST = 16'h0000;
  localparam logic [11:0] IAD_DM_ADDR_RST = 12'h000;
  localparam logic [14:0] IAD_PF_ADDR_RST = 15'h0000;

  typedef enum logic [1:0] {
    IAD_RG_NONE,
    IAD_RG_DATA,
    IAD_RG_FLASH
  } iad_region_t;

  typedef enum logic [2:0] {
    IAD_ST_IDLE,
    IAD_ST_DMEM,
    IAD_ST_NULL,
    IAD_ST_FL1,
    IAD_ST_FL2
  } iad_state_t;

  typedef struct packed {
    logic [7:0] hi;
    logic [7:0] lo;
  } iad_ptr_t;

  typedef struct packed {
    logic en;
    logic sel;
    logic hi;
    logic [7:0] data;
  } iad_pwr_t;

  typedef struct packed {
    logic valid;
    logic sel;
    logic we;
    logic inc;
    logic [7:0] wdata;
  } iad_acc_t;

  typedef struct packed {
    logic valid;
    logic [7:0] rdata;
  } iad_rsp_t;

  typedef struct packed {
    iad_region_t rg;
    logic [11:0] addr;
  } iad_map_t;
endpackage : iad_pkg
`default_nettype wire

// >>> test/iad_assertions.sv
// Port checks for the indirect address decoder.
`timescale 1ns/1ps
`default_nettype none
module iad_checker (
  input wire logic clk,
  input wire logic rst,
  input wire iad_pkg::iad_pwr_t ptr_wr,
  input wire iad_pkg::iad_acc_t acc,
  input wire logic [13:0] pf_rdata,
  input wire iad_pkg::iad_ptr_t ptr0,
  input wire iad_pkg::iad_ptr_t ptr1,
  input wire logic busy,
  input wire iad_pkg::iad_rsp_t rsp,
  input wire logic dm_en,
  input wire logic dm_we,
  input wire logic [7:0] dm_wdata,
  input wire logic [11:0] dm_addr,
  input wire logic pf_en,
  input wire logic [14:0] pf_addr
);
  logic [15:0] p;
  logic [15:0] n;
  logic [11:0] la;
  logic [7:0] pl;
  logic tk;
  logic td;
  logic ln;
  logic dw;
  assign p = acc.sel ? ptr1 : ptr0;
  assign n = p - 16'h2000;
  assign la = {5'(n / 16'd80), 7'(7'h20 + n % 16'd80)};
  assign pl = pf_rdata[7:0];
  assign tk = acc.valid && !busy;
  assign td = p <= 16'h0fff;
  assign ln = p >= 16'h2000 && p <= 16'h29af;
  assign dw = tk && ((td && p[6:1] != 6'h00) || ln);
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  a_flash_cycles: assert property (tk && p[15] |=>
    pf_en [*2] ##1 !pf_en && rsp.valid) else $error("flash timing");
  a_flash_addr: assert property (tk && p[15] |=>
    {1'b1, pf_addr} == $past(p)) else $error("flash address");
  a_flash_low: assert property (tk && p[15] && !acc.we |->
    ##3 rsp.rdata == $past(pl)) else $error("flash byte");
  a_flash_nowr: assert property (tk && p[15] && acc.we |=>
    (!dm_en) [*2] ##1 rsp.rdata == 8'h00) else $error("flash write");
  a_trad_addr: assert property (tk && td && p[6:1] != 6'h00 |=>
    dm_en && {4'h0, dm_addr} == $past(p)) else $error("data address");
  a_slot_zero: assert property (tk && td && p[6:1] == 6'h00 |=>
    !dm_en ##1 rsp.valid && rsp.rdata == 8'h00) else $error("slot");
  a_lin_map: assert property (tk && ln |=>
    dm_en && dm_addr == $past(la)) else $error("linear address");
  a_resv_zero: assert property (tk && !td && !ln && !p[15] |=>
    !dm_en && !pf_en ##1 rsp.rdata == 8'h00) else $error("reserved");
  a_ptr_load: assert property (ptr_wr.en && !ptr_wr.sel && ptr_wr.hi |=>
    ptr0.hi == $past(ptr_wr.data)) else $error("pointer byte");
  a_data_write: assert property (dw |=>
    dm_we == $past(acc.we) && dm_wdata == $past(acc.wdata))
    else $error("data write");
  a_busy_data: assert property (tk && !p[15] |=>
    busy ##1 !busy && rsp.valid) else $error("data timing");
endmodule : iad_checker
`default_nettype wire

// >>> test/iad_mem_model.sv
// Data memory and flash seen by the decoder.
`timescale 1ns/1ps
`default_nettype none
module iad_mem_model (
  input wire logic dm_en,
  input wire logic [11:0] dm_addr,
  input wire logic pf_en,
  input wire logic [14:0] pf_addr,
  output logic [7:0] dm_rdata,
  output logic dm_impl,
  output logic [13:0] pf_rdata
);
  // Buses invert outside a strobe, so a stale sample shows up as bad data.
  assign dm_impl = dm_addr[11:7] != 5'h1f;
  assign dm_rdata = {8{~dm_en}} ^ dm_addr[7:0] ^ 8'ha5;
  assign pf_rdata = {14{~pf_en}} ^ pf_addr[13:0] ^ 14'h12c3;
endmodule : iad_mem_model
`default_nettype wire

// >>> test/testbench.sv
// Self-checking bench for the indirect address decoder.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  iad_pkg::iad_pwr_t ptr_wr = '0;
  iad_pkg::iad_acc_t acc = '0;
  iad_pkg::iad_ptr_t ptr0, ptr1;
  iad_pkg::iad_rsp_t rsp;
  logic busy, dm_en, dm_we, dm_impl, pf_en;
  logic [7:0] dm_rdata, dm_wdata, e;
  logic [11:0] dm_addr;
  logic [13:0] pf_rdata;
  logic [14:0] pf_addr;
  logic [15:0] p;
  logic [31:0] v;
  logic [7:0] expq[$];
  logic [15:0] corner [9] = '{16'h0000, 16'h0081, 16'h0f85, 16'h1000,
    16'h29af, 16'h29b0, 16'h7fff, 16'h8000, 16'hffff};
  int miscompares = 0, compares = 0, seed = 5, cyc = 0;
  always #12.5 clk = ~clk;
  iad_decoder dut_u (.clk, .rst, .ptr_wr, .acc, .dm_rdata, .dm_impl,
    .pf_rdata, .ptr0, .ptr1, .busy, .rsp, .dm_en, .dm_we, .dm_addr,
    .dm_wdata, .pf_en, .pf_addr);
  iad_mem_model mem_u (.dm_en, .dm_addr, .pf_en, .pf_addr, .dm_rdata,
    .dm_impl, .pf_rdata);
  function automatic logic [7:0] exp_rd(logic [15:0] a, logic we);
    logic [15:0] n;
    logic [11:0] d;
    n = a - 16'h2000;
    d = a <= 16'h0fff ? a[11:0] : {5'(n / 16'd80), 7'(7'h20 + n % 16'd80)};
    if (we || (a <= 16'h0fff && a[6:1] == 6'h00)) return 8'h00;
    if (a[15]) return a[7:0] ^ 8'hc3;
    if (a > 16'h0fff && (a < 16'h2000 || a > 16'h29af)) return 8'h00;
    if (d[11:7] == 5'h1f) return 8'h00;
    return d[7:0] ^ 8'ha5;
  endfunction : exp_rd
  task automatic chk(logic [15:0] got, logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic set_ptr(logic s, logic [15:0] a);
    ptr_wr <= '{1'b1, s, 1'b1, a[15:8]};
    @(posedge clk);
    ptr_wr <= '{1'b1, s, 1'b0, a[7:0]};
    @(posedge clk);
    ptr_wr <= '0;
    @(posedge clk);
    chk(s ? ptr1 : ptr0, a);
  endtask : set_ptr
  task automatic access(logic s, logic we, logic inc, logic [15:0] a);
    expq.push_back(exp_rd(a, we));
    acc <= '{1'b1, s, we, inc, 8'h3c};
    @(posedge clk);
    acc <= '0;
    @(negedge clk);
    while (busy === 1'b1) @(negedge clk);
    @(posedge clk);
  endtask : access
  task automatic report_and_stop();
    if (miscompares == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : report_and_stop
  always @(negedge clk) begin
    if (rsp.valid === 1'b1) begin
      e = expq.size() > 0 ? expq.pop_front() : 8'hxx;
      chk({8'h00, rsp.rdata}, {8'h00, e});
    end
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      miscompares++;
      report_and_stop();
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    // Slots, unimplemented, bank and region edges, both flash ends.
    for (int i = 0; i < 9; i++) begin
      set_ptr(1'b0, corner[i]);
      access(1'b0, 1'b0, 1'b0, corner[i]);
    end
    set_ptr(1'b1, 16'h204f);
    access(1'b1, 1'b0, 1'b1, 16'h204f);
    chk(ptr1, 16'h2050);
    access(1'b1, 1'b1, 1'b0, 16'h2050);
    for (int i = 0; i < 40; i++) begin
      v = $random(seed);
      p = v[17] ? v[15:0] : v[16] ? 16'h2000 + 16'(v[11:0] % 12'd2480)
        : {4'h0, v[11:0]};
      set_ptr(v[21], p);
      access(v[21], v[20], 1'b0, p);
    end
    repeat (2) @(posedge clk);
    chk(16'(expq.size()), 16'h0000);
    report_and_stop();
  end
endmodule : testbench
bind iad_decoder iad_checker u_chk (.clk, .rst, .ptr_wr, .acc, .pf_rdata,
  .ptr0, .ptr1, .busy, .rsp, .dm_en, .dm_we, .dm_wdata, .dm_addr, .pf_en,
  .pf_addr);
`default_nettype wire
